/* File: rtl/chb_pkg.sv */
package chb_pkg;

  // host bus addresses
  localparam logic [7:0] ADDR_CLK_SRC  = 8'h73;
  localparam logic [7:0] ADDR_STATUS   = 8'h80;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h81;
  localparam logic [7:0] ADDR_DEC_OFS  = 8'hD5;
  localparam logic [7:0] ADDR_DEC_PCM  = 8'hD6;
  localparam logic [7:0] ADDR_DEC_ADM  = 8'hDA;
  localparam logic [7:0] ADDR_ENC_VAD  = 8'hE4;
  localparam logic [7:0] ADDR_ENC_OFS  = 8'hE5;
  localparam logic [7:0] ADDR_ENC_PCM  = 8'hE6;
  localparam logic [7:0] ADDR_ENC_ADM  = 8'hEA;

  // status and interrupt-enable bit positions
  localparam int unsigned BIT_DEC_ADM = 0;
  localparam int unsigned BIT_DEC_PCM = 1;
  localparam int unsigned BIT_DEC_VAD = 2;
  localparam int unsigned BIT_ENC_ADM = 4;
  localparam int unsigned BIT_ENC_PCM = 5;
  localparam int unsigned BIT_ENC_VAD = 6;

  // clock source control: tx high impedance between frames
  localparam int unsigned BIT_TX_HIZ = 9;

  // reset values
  localparam logic [15:0] INT_CTRL_RST = 16'h0000;
  localparam logic [15:0] CLK_SRC_RST  = 16'h0000;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;

  // counts
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [4:0] WORD8_BITS   = 5'h08;
  localparam logic [4:0] WORD16_BITS  = 5'h10;
  localparam int unsigned ADM_CHANNELS = 2;

  // host bus transaction phase
  typedef enum logic [1:0] {CB_CMD, CB_WDATA, CB_REPLY, CB_DONE} chb_cb_state_t;

endpackage : chb_pkg

/* File: rtl/chb_top.sv */
module chb_top (
  // system
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // decoder results
  input  wire logic [15:0] dec_offset_i,
  input  wire logic [15:0] dec_pcm_i,
  input  wire logic        dec_pcm_stb_i,
  input  wire logic        dec_adm_bit_i,
  input  wire logic        dec_adm_stb_i,
  input  wire logic        dec_transcode_i,
  input  wire logic        dec_xcode_bit_i,
  input  wire logic        dec_xcode_stb_i,
  input  wire logic        dec_vad_det_i,
  // encoder results
  input  wire logic [15:0] enc_vad_level_i,
  input  wire logic [15:0] enc_offset_load_i,
  input  wire logic [15:0] enc_offset_est_i,
  input  wire logic        enc_idle_track_i,
  input  wire logic [15:0] enc_pcm_i,
  input  wire logic        enc_pcm_stb_i,
  input  wire logic        enc_adm_bit_i,
  input  wire logic        enc_adm_stb_i,
  input  wire logic        enc_vad_det_i,
  // host control bus pins
  input  wire logic        host_select_n_i,
  input  wire logic        cbus_sclk_i,
  input  wire logic        cbus_cmd_i,
  output logic             cbus_reply_o,
  output logic             cbus_reply_oe_o,
  output logic             irq_n_o,
  // burst port pins
  input  wire logic        bclk_i,
  input  wire logic        bsync_i,
  input  wire logic        brx_i,
  output logic             btx_o,
  output logic             btx_oe_o,
  // burst word exchange with the codec core
  input  wire logic        burst_word16_i,
  input  wire logic [15:0] tx_word_i,
  output logic [15:0]      rx_word_o,
  output logic             rx_valid_o
);

  // result registers
  logic [15:0] dec_ofs_r, dec_pcm_r, enc_vad_r, enc_ofs_r, enc_pcm_r;
  logic [7:0]  adm_byte_r [chb_pkg::ADM_CHANNELS];
  logic [6:0]  adm_sh_r   [chb_pkg::ADM_CHANNELS];
  logic [2:0]  adm_cnt_r  [chb_pkg::ADM_CHANNELS];
  logic        adm_upd    [chb_pkg::ADM_CHANNELS];
  logic        adm_bit    [chb_pkg::ADM_CHANNELS];
  logic        adm_stb    [chb_pkg::ADM_CHANNELS];
  logic [15:0] int_en_r, clk_src_r;
  logic [7:0]  flags_r, flags_nxt, flag_set, flag_clr;
  logic        irq_pend_r, irq_pend_nxt;

  // host bus state
  logic        sclk_m, sclk_s, sclk_d, csn_m, csn_s, din_m, din_s;
  chb_pkg::chb_cb_state_t cb_state_r;
  logic [2:0]  cb_bit_r;
  logic [6:0]  cb_rx_r;
  logic        cb_second_r;
  logic [7:0]  cb_wd_hi_r;
  logic [15:0] cb_rep_r;
  logic        cb_rep_q_r;
  logic [7:0]  cb_cmd_r;

  // burst domain state
  logic        b16_m, b16_s, hiz_m, hiz_s, bsync_d_r, brun_r, bdone_tgl_r;
  logic [4:0]  bcnt_r;
  logic [15:0] btx_sh_r, brx_sh_r, tx_hold_r;
  logic        btx_q_r;
  logic        done_m, done_s, done_d;
  logic [15:0] rx_word_r;
  logic        rx_valid_r;

  // adm bit sources; the transcoder replaces the decoder stream
  assign adm_bit[0] = dec_transcode_i ? dec_xcode_bit_i : dec_adm_bit_i;
  assign adm_stb[0] = dec_transcode_i ? dec_xcode_stb_i : dec_adm_stb_i;
  assign adm_bit[1] = enc_adm_bit_i;
  assign adm_stb[1] = enc_adm_stb_i;

  // adm byte packers, first bit lands in the msb
  for (genvar g = 0; g < chb_pkg::ADM_CHANNELS; g++) begin : g_adm
    assign adm_upd[g] = ce_i && adm_stb[g] && (adm_cnt_r[g] == chb_pkg::LAST_BIT);
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        adm_sh_r[g]   <= 7'h00;
        adm_cnt_r[g]  <= 3'h0;
        adm_byte_r[g] <= chb_pkg::BYTE_RST;
      end else if (ce_i && adm_stb[g]) begin
        adm_sh_r[g]  <= {adm_sh_r[g][5:0], adm_bit[g]};
        adm_cnt_r[g] <= adm_cnt_r[g] + 3'h1;
        if (adm_upd[g]) begin
          adm_byte_r[g] <= {adm_sh_r[g], adm_bit[g]};
        end
      end
    end
  end

  // word results sampled from the core
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_ofs_r <= chb_pkg::WORD_RST;
      dec_pcm_r <= chb_pkg::WORD_RST;
      enc_vad_r <= chb_pkg::WORD_RST;
      enc_ofs_r <= chb_pkg::WORD_RST;
      enc_pcm_r <= chb_pkg::WORD_RST;
    end else if (ce_i) begin
      dec_ofs_r <= dec_offset_i;
      if (dec_pcm_stb_i) dec_pcm_r <= dec_pcm_i;
      if (enc_pcm_stb_i) enc_pcm_r <= enc_pcm_i;
      // a positive envelope cannot be coded, so clamp it to zero
      enc_vad_r <= enc_vad_level_i[15] ? enc_vad_level_i : chb_pkg::WORD_RST;
      enc_ofs_r <= enc_idle_track_i ? enc_offset_est_i : enc_offset_load_i;
    end
  end

  // host pin synchronisers; the first stage is never looked at
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {csn_m, csn_s}           <= 2'h3;
      {din_m, din_s}           <= 2'h0;
    end else if (ce_i) begin
      {sclk_m, sclk_s, sclk_d} <= {cbus_sclk_i, sclk_m, sclk_s};
      {csn_m, csn_s}           <= {host_select_n_i, csn_m};
      {din_m, din_s}           <= {cbus_cmd_i, din_m};
    end
  end

  // host bus decode
  wire       sclk_rise = ce_i && sclk_s && !sclk_d && !csn_s;
  wire       sclk_fall = ce_i && !sclk_s && sclk_d && !csn_s;
  wire [7:0] byte_in   = {cb_rx_r, din_s};
  wire       byte_end  = sclk_rise && (cb_bit_r == chb_pkg::LAST_BIT);
  wire       is_rd2    = (byte_in == chb_pkg::ADDR_DEC_OFS) || (byte_in == chb_pkg::ADDR_DEC_PCM)
                      || (byte_in == chb_pkg::ADDR_ENC_VAD) || (byte_in == chb_pkg::ADDR_ENC_OFS)
                      || (byte_in == chb_pkg::ADDR_ENC_PCM);
  wire       is_rd1    = (byte_in == chb_pkg::ADDR_STATUS) || (byte_in == chb_pkg::ADDR_DEC_ADM)
                      || (byte_in == chb_pkg::ADDR_ENC_ADM);
  wire       is_wr     = (byte_in == chb_pkg::ADDR_INT_CTRL) || (byte_in == chb_pkg::ADDR_CLK_SRC);
  wire       cmd_end   = byte_end && (cb_state_r == chb_pkg::CB_CMD);
  wire       rd_stb    = cmd_end && (is_rd1 || is_rd2);
  wire       wr_stb    = byte_end && (cb_state_r == chb_pkg::CB_WDATA) && cb_second_r;
  wire [15:0] wr_data  = {cb_wd_hi_r, byte_in};
  wire       wr_int_ctl = wr_stb && (cb_cmd_r == chb_pkg::ADDR_INT_CTRL);
  wire       wr_clk_src = wr_stb && (cb_cmd_r == chb_pkg::ADDR_CLK_SRC);
  wire [7:0] status_val = flags_r;

  // reply word, one-byte replies are left aligned
  wire [15:0] rd_val =
      (byte_in == chb_pkg::ADDR_DEC_OFS) ? dec_ofs_r :
      (byte_in == chb_pkg::ADDR_DEC_PCM) ? dec_pcm_r :
      (byte_in == chb_pkg::ADDR_ENC_VAD) ? enc_vad_r :
      (byte_in == chb_pkg::ADDR_ENC_OFS) ? enc_ofs_r :
      (byte_in == chb_pkg::ADDR_ENC_PCM) ? enc_pcm_r :
      (byte_in == chb_pkg::ADDR_DEC_ADM) ? {adm_byte_r[0], chb_pkg::BYTE_RST} :
      (byte_in == chb_pkg::ADDR_ENC_ADM) ? {adm_byte_r[1], chb_pkg::BYTE_RST} :
      {status_val, chb_pkg::BYTE_RST};

  // host bus sequencer; select high abandons whatever is under way
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cb_state_r  <= chb_pkg::CB_CMD;
      cb_bit_r    <= 3'h0;
      cb_rx_r     <= 7'h00;
      cb_second_r <= 1'b0;
      cb_wd_hi_r  <= chb_pkg::BYTE_RST;
      cb_rep_r    <= chb_pkg::WORD_RST;
      cb_rep_q_r  <= 1'b0;
    end else if (ce_i && csn_s) begin
      cb_state_r  <= chb_pkg::CB_CMD;
      cb_bit_r    <= 3'h0;
      cb_second_r <= 1'b0;
    end else begin
      if (sclk_rise) begin
        cb_rx_r  <= byte_in[6:0];
        cb_bit_r <= cb_bit_r + 3'h1;
      end
      unique case (cb_state_r)
        chb_pkg::CB_CMD: begin
          if (byte_end) begin
            cb_rep_r   <= rd_val;
            cb_state_r <= (is_rd1 || is_rd2) ? chb_pkg::CB_REPLY :
                          is_wr ? chb_pkg::CB_WDATA : chb_pkg::CB_DONE;
          end
        end
        chb_pkg::CB_WDATA: begin
          if (byte_end) begin
            cb_wd_hi_r  <= byte_in;
            cb_second_r <= 1'b1;
            if (cb_second_r) cb_state_r <= chb_pkg::CB_DONE;
          end
        end
        chb_pkg::CB_REPLY: begin
          if (sclk_fall) begin
            cb_rep_q_r <= cb_rep_r[15];
            cb_rep_r   <= {cb_rep_r[14:0], 1'b0};
          end
        end
        chb_pkg::CB_DONE: begin
          cb_state_r <= chb_pkg::CB_DONE;
        end
      endcase
    end
  end

  assign cbus_reply_o    = cb_rep_q_r;
  assign cbus_reply_oe_o = (cb_state_r == chb_pkg::CB_REPLY) && !csn_s;

  // writable setup words reached by the host
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      int_en_r  <= chb_pkg::INT_CTRL_RST;
      clk_src_r <= chb_pkg::CLK_SRC_RST;
    end else begin
      if (wr_int_ctl) int_en_r <= wr_data;
      if (wr_clk_src) clk_src_r <= wr_data;
    end
  end

  // command byte kept so the write at the last data bit knows its target
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) cb_cmd_r <= chb_pkg::BYTE_RST;
    else if (cmd_end) cb_cmd_r <= byte_in;
  end

  // flag events and clears; an event in the clearing cycle survives
  always_comb begin
    flag_set = 8'h00;
    flag_set[chb_pkg::BIT_DEC_ADM] = adm_upd[0];
    flag_set[chb_pkg::BIT_DEC_PCM] = ce_i && dec_pcm_stb_i;
    flag_set[chb_pkg::BIT_ENC_ADM] = adm_upd[1];
    flag_set[chb_pkg::BIT_ENC_PCM] = ce_i && enc_pcm_stb_i;
    flag_clr = 8'h00;
    flag_clr[chb_pkg::BIT_DEC_ADM] = rd_stb && (byte_in == chb_pkg::ADDR_DEC_ADM);
    flag_clr[chb_pkg::BIT_DEC_PCM] = rd_stb && (byte_in == chb_pkg::ADDR_DEC_PCM);
    flag_clr[chb_pkg::BIT_ENC_ADM] = rd_stb && (byte_in == chb_pkg::ADDR_ENC_ADM);
    flag_clr[chb_pkg::BIT_ENC_PCM] = rd_stb && (byte_in == chb_pkg::ADDR_ENC_PCM);
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    flags_nxt[chb_pkg::BIT_DEC_VAD] = dec_vad_det_i;
    flags_nxt[chb_pkg::BIT_ENC_VAD] = enc_vad_det_i;
    irq_pend_nxt = (irq_pend_r && !(rd_stb && (byte_in == chb_pkg::ADDR_STATUS)))
                || |(flag_set & int_en_r[7:0]);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r    <= chb_pkg::BYTE_RST;
      irq_pend_r <= 1'b0;
    end else if (ce_i) begin
      flags_r    <= flags_nxt;
      irq_pend_r <= irq_pend_nxt;
    end
  end

  assign irq_n_o = !irq_pend_r;

  // burst domain: configuration levels cross by two flip-flops
  always_ff @(posedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      {b16_m, b16_s} <= 2'h0;
      {hiz_m, hiz_s} <= 2'h0;
    end else begin
      {b16_m, b16_s} <= {burst_word16_i, b16_m};
      {hiz_m, hiz_s} <= {clk_src_r[chb_pkg::BIT_TX_HIZ], hiz_m};
    end
  end

  // frame start on the sync edge, clock 0 of the slot
  wire       bstart = bsync_i && !bsync_d_r;
  wire [4:0] blen   = b16_s ? chb_pkg::WORD16_BITS : chb_pkg::WORD8_BITS;
  wire       bshift = brun_r && (bcnt_r != blen);

  // transmit side, one bit per rising edge from clock 1
  always_ff @(posedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      bsync_d_r <= 1'b0;
      brun_r    <= 1'b0;
      bcnt_r    <= 5'h00;
      btx_sh_r  <= chb_pkg::WORD_RST;
      btx_q_r   <= 1'b0;
    end else begin
      bsync_d_r <= bsync_i;
      if (bstart) begin
        brun_r   <= 1'b1;
        bcnt_r   <= 5'h00;
        // an 8-bit word is moved into the top byte so the msb leads
        btx_sh_r <= b16_s ? tx_hold_r : {tx_hold_r[7:0], chb_pkg::BYTE_RST};
      end else if (bshift) begin
        btx_q_r  <= btx_sh_r[15];
        btx_sh_r <= {btx_sh_r[14:0], 1'b0};
        bcnt_r   <= bcnt_r + 5'h01;
      end else if (brun_r) begin
        brun_r <= 1'b0;
      end
    end
  end

  assign btx_o    = btx_q_r;
  assign btx_oe_o = brun_r || !hiz_s;

  // receive side, sampled mid-bit on the falling edge
  always_ff @(negedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      brx_sh_r    <= chb_pkg::WORD_RST;
      bdone_tgl_r <= 1'b0;
    end else if (brun_r && (bcnt_r != 5'h00)) begin
      brx_sh_r <= {brx_sh_r[14:0], brx_i};
      if (bcnt_r == blen) bdone_tgl_r <= !bdone_tgl_r;
    end
  end

  // word hand-off: the done toggle crosses, words stay put until the next frame
  wire bdone_evt = done_s ^ done_d;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {done_m, done_s, done_d} <= 3'h0;
      rx_word_r  <= chb_pkg::WORD_RST;
      rx_valid_r <= 1'b0;
      tx_hold_r  <= chb_pkg::WORD_RST;
    end else if (ce_i) begin
      {done_m, done_s, done_d} <= {bdone_tgl_r, done_m, done_s};
      rx_valid_r <= bdone_evt;
      if (bdone_evt) begin
        rx_word_r <= burst_word16_i ? brx_sh_r : {chb_pkg::BYTE_RST, brx_sh_r[7:0]};
        tx_hold_r <= tx_word_i;
      end
    end
  end

  assign rx_word_o  = rx_word_r;
  assign rx_valid_o = rx_valid_r && ce_i;

  // checks
  AST_DEC_PCM_VAL: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && dec_pcm_stb_i) |=> (dec_pcm_r == $past(dec_pcm_i)))
    else $error("decoder pcm result not loaded");
  AST_DEC_PCM_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && dec_pcm_stb_i && int_en_r[chb_pkg::BIT_DEC_PCM]) |=> !irq_n_o)
    else $error("decoder pcm update raised no interrupt");
  AST_ADM_BYTE_RATE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (adm_byte_r[0] != $past(adm_byte_r[0])) |-> $past(adm_cnt_r[0]) == chb_pkg::LAST_BIT)
    else $error("decoder adm byte changed off the eighth bit");
  AST_ENC_ADM_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
    (adm_upd[1] && int_en_r[chb_pkg::BIT_ENC_ADM]) |=> irq_pend_r && flags_r[chb_pkg::BIT_ENC_ADM])
    else $error("encoder adm update raised no interrupt");
  AST_ENC_VAD_SIGN: assert property (@(posedge mclk_i) disable iff (rst_i)
    enc_vad_r[15] || (enc_vad_r == chb_pkg::WORD_RST))
    else $error("envelope level positive");
  AST_ENC_OFS_TRACK: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && enc_idle_track_i) |=> (enc_ofs_r == $past(enc_offset_est_i)))
    else $error("offset estimate not tracked");
  AST_STATUS_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_stb && byte_in == chb_pkg::ADDR_STATUS && flag_set == 8'h00) |=> irq_n_o)
    else $error("status read left interrupt pending");
  AST_SELECT_ABORT: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && csn_s) |=> (cb_state_r == chb_pkg::CB_CMD && cb_bit_r == 3'h0 && !cbus_reply_oe_o))
    else $error("transaction not abandoned on deselect");
  AST_TX_HIZ: assert property (@(posedge bclk_i) disable iff (rst_i)
    (!brun_r && hiz_s) |-> !btx_oe_o)
    else $error("tx driven between frames");

endmodule : chb_top

/* File: tb/chb_far_end.sv */
module chb_far_end (
  // burst pins as seen by the framing controller
  input  wire logic btx_i,
  output logic      bclk_o,
  output logic      bsync_o,
  output logic      brx_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock starts and rests low; it runs only in frames, their lead-in clocks and three clocks during reset
  initial begin
    bclk_o = 1'b0;
    bsync_o = 1'b0;
    brx_o = 1'b0;
  end

  // sync-low clocks; also lets the word-length synchroniser settle
  task automatic clocks(input int n);
    repeat (n) begin
      #6 bclk_o = 1'b1;
      #6 bclk_o = 1'b0;
    end
  endtask : clocks

  // one slot per frame on a clock shared by both directions
  task automatic frame(input int len, input logic [15:0] rx_w,
                       output logic [15:0] tx_w);
    tx_w = 16'h0000;
    clocks(3);
    bsync_o = 1'b1;                                        // word starts at edge 0
    for (int e = 0; e <= len + 1; e++) begin
      #6 bclk_o = 1'b1;
      #1 bsync_o = 1'b0;                                   // one clock wide
      brx_o = (e >= 1 && e <= len) ? rx_w[len - e] : ~brx_o; // msb first from edge 1
      #5 bclk_o = 1'b0;
      if (e >= 1 && e <= len) tx_w[len - e] = btx_i;
    end
    // released line must not keep showing the last bit
    brx_o = ~brx_o;
  endtask : frame
endmodule : chb_far_end

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // design pins
  logic        mclk_i, rst_i, ce_i, dec_pcm_stb_i, dec_adm_bit_i, dec_adm_stb_i;
  logic        dec_transcode_i, dec_xcode_bit_i, dec_xcode_stb_i, dec_vad_det_i;
  logic        enc_idle_track_i, enc_pcm_stb_i, enc_adm_bit_i, enc_adm_stb_i, enc_vad_det_i;
  logic        host_select_n_i, cbus_sclk_i, cbus_cmd_i, cbus_reply_o, cbus_reply_oe_o;
  logic        irq_n_o, bclk_i, bsync_i, brx_i, btx_o, btx_oe_o, burst_word16_i, rx_valid_o;
  logic [15:0] dec_offset_i, dec_pcm_i, enc_vad_level_i, enc_offset_load_i, enc_offset_est_i;
  logic [15:0] enc_pcm_i, tx_word_i, rx_word_o;
  // bench state
  logic        btx_line;
  logic [15:0] v, prev, tw, got, rd_q[$], rx_q[$];
  logic [31:0] seed = 32'hC1DFF60D;
  int          fails = 0, compares = 0, len;
  int          bp [6] = '{0, 1, 4, 5, 0, 5};
  int          nb [6] = '{1, 2, 1, 2, 1, 2};
  logic [7:0]  ad [6] = '{chb_pkg::ADDR_DEC_ADM, chb_pkg::ADDR_DEC_PCM, chb_pkg::ADDR_ENC_ADM,
                          chb_pkg::ADDR_ENC_PCM, chb_pkg::ADDR_DEC_ADM, chb_pkg::ADDR_ENC_PCM};
  event        rd_ev;

  chb_top DUT (.*);

  // undriven tx line toggles so a stale bit cannot pass
  assign btx_line = btx_oe_o ? btx_o : bclk_i;
  chb_far_end far (.btx_i(btx_line), .bclk_o(bclk_i), .bsync_o(bsync_i), .brx_o(brx_i));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs

  task automatic summarize();
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : cmp

  // one host transaction; sclk made here, each phase 5 mclk wide
  task automatic cbus(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                      output logic [15:0] r);
    logic [23:0] s;
    s = (n == 2) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
    r = 16'h0000;
    @(posedge mclk_i) host_select_n_i <= 1'b0;
    for (int i = 0; i < 8 + 8 * n; i++) begin
      cbus_sclk_i <= 1'b0;
      cbus_cmd_i <= s[23 - i];
      repeat (5) @(posedge mclk_i);
      // a released reply line reads unknown, so a missing enable fails the compare
      if (i >= 8) r = {r[14:0], cbus_reply_oe_o ? cbus_reply_o : 1'bx};
      cbus_sclk_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
    end
    cbus_sclk_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    host_select_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask : cbus

  task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e);
    rd_q.push_back(e);
    cbus(a, 16'h0000, n, got);
    -> rd_ev;
  endtask : rd

  // oldest note against each finished read or received word
  always @(rd_ev) cmp(got, rd_q.pop_front());
  always @(posedge mclk_i)
    if (rx_valid_o === 1'b1) cmp(rx_word_o, rx_q.pop_front());

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_i);
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end

  initial begin
    {rst_i, ce_i, host_select_n_i} = 3'b111;
    {cbus_sclk_i, cbus_cmd_i, dec_pcm_stb_i, dec_adm_bit_i, dec_adm_stb_i, dec_transcode_i,
     dec_xcode_bit_i, dec_xcode_stb_i, dec_vad_det_i, enc_idle_track_i, enc_pcm_stb_i,
     enc_adm_bit_i, enc_adm_stb_i, enc_vad_det_i, burst_word16_i} = 15'h0000;
    {dec_offset_i, dec_pcm_i, enc_vad_level_i, enc_offset_load_i, enc_offset_est_i, enc_pcm_i,
     tx_word_i} = 112'h0;
    far.clocks(3);
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // live readbacks, envelope clamp and offset source select
    for (int j = 0; j < 4; j++) begin
      v = xs();
      @(posedge mclk_i) begin
        dec_offset_i <= v;
        enc_vad_level_i <= {j[0], v[14:0]};
        enc_offset_load_i <= v;
        enc_offset_est_i <= ~v;
        enc_idle_track_i <= j[1];
      end
      rd(chb_pkg::ADDR_DEC_OFS, 2, v);
      rd(chb_pkg::ADDR_ENC_VAD, 2, j[0] ? {1'b1, v[14:0]} : 16'h0000);
      rd(chb_pkg::ADDR_ENC_OFS, 2, j[1] ? ~v : v);
    end
    // select lifted after four bits; next read must be clean
    @(posedge mclk_i) host_select_n_i <= 1'b0;
    repeat (4) begin
      repeat (5) @(posedge mclk_i) cbus_sclk_i <= 1'b1;
      repeat (5) @(posedge mclk_i) cbus_sclk_i <= 1'b0;
    end
    host_select_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(chb_pkg::ADDR_DEC_OFS, 2, v);
    // each result event: interrupt, status clear, flag clear; last one masked
    cbus(chb_pkg::ADDR_INT_CTRL, 16'h0033, 2, tw);
    for (int k = 0; k < 6; k++) begin
      v = xs();
      if (k == 5) cbus(chb_pkg::ADDR_INT_CTRL, 16'h0000, 2, tw);
      @(posedge mclk_i) begin
        dec_transcode_i <= (k == 4);
        dec_pcm_i <= v;
        enc_pcm_i <= v;
      end
      for (int i = 7; i >= 0; i--) begin
        @(posedge mclk_i) begin
          {dec_adm_bit_i, enc_adm_bit_i, dec_xcode_bit_i} <= {3{v[i]}};
          {dec_adm_stb_i, enc_adm_stb_i, dec_xcode_stb_i} <= {k == 0, k == 2, k == 4};
          {dec_pcm_stb_i, enc_pcm_stb_i} <= {k == 1 && i == 0, (k == 3 || k == 5) && i == 0};
        end
        @(posedge mclk_i) begin
          {dec_adm_stb_i, enc_adm_stb_i, dec_xcode_stb_i} <= 3'h0;
          {dec_pcm_stb_i, enc_pcm_stb_i} <= 2'h0;
        end
      end
      repeat (6) @(posedge mclk_i);
      cmp({15'h0000, irq_n_o}, {15'h0000, k == 5});
      rd(chb_pkg::ADDR_STATUS, 1, {8'h00, 8'h01 << bp[k]});
      cmp({15'h0000, irq_n_o}, 16'h0001);
      rd(ad[k], nb[k], nb[k] == 2 ? v : {8'h00, v[7:0]});
      rd(chb_pkg::ADDR_STATUS, 1, 16'h0000);
    end
    // burst frames: 8 then 16 bits, tx released between frames until bit 9 cleared
    cbus(chb_pkg::ADDR_CLK_SRC, 16'h0200, 2, tw);
    prev = 16'h0000;
    for (int f = 0; f < 7; f++) begin
      len = (f < 3) ? 8 : 16;
      if (f == 6) cbus(chb_pkg::ADDR_CLK_SRC, 16'h0000, 2, tw);
      @(posedge mclk_i) begin
        burst_word16_i <= (len == 16);
        tx_word_i <= xs();
      end
      v = xs();
      if (len == 8) v[15:8] = 8'h00;
      rx_q.push_back(v);
      far.frame(len, v, tw);
      repeat (8) @(posedge mclk_i);
      cmp(tw, (len == 16) ? prev : {8'h00, prev[7:0]});
      prev = tx_word_i;
      cmp({15'h0000, btx_oe_o}, {15'h0000, f == 6});
    end
    repeat (10) @(posedge mclk_i);
    // every noted read and word must have been answered
    compares++;
    if (rd_q.size() != 0 || rx_q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: %0d notes left unanswered", $time, rd_q.size() + rx_q.size());
    end
    summarize();
  end
endmodule : testbench
